/* include/led_plane_pkg.sv */
// constants, types and helper functions for the led intensity and plane block
package led_plane_pkg;
    localparam int CLK_NS          = 25;
    localparam int DIGIT_PERIOD_NS = 122000;
    localparam int SEC_NS          = 1000000000;
    localparam int STEPS           = 256;
    // least step length rounds down so a digit period never exceeds its figure
    localparam int STEP_CYC        = DIGIT_PERIOD_NS / (STEPS * CLK_NS);
    localparam logic [31:0] SEC_CYC_DEF = 32'(SEC_NS / CLK_NS);

    localparam logic [6:0] ADDR_PANEL  = 7'h02;
    localparam logic [6:0] ADDR_DIGIT0 = 7'h03;
    localparam logic [6:0] ADDR_DIGIT1 = 7'h04;
    localparam logic [6:0] ADDR_DRIVER = 7'h08;
    localparam logic [6:0] ADDR_PTR_LO = 7'h09;
    localparam logic [6:0] ADDR_PTR_HI = 7'h0a;
    localparam logic [6:0] ADDR_SEQ    = 7'h0b;
    localparam logic [6:0] ADDR_CONFIG = 7'h0d;
    localparam logic [6:0] ADDR_SCALE  = 7'h0e;

    localparam int CFG_DEPTH_BIT = 7;
    localparam int SEQ_FAST_BIT  = 7;
    localparam int SEQ_AUTO_BIT  = 6;
    localparam int SEQ_N_W       = 6;
    localparam int PTR_W         = 14;
    localparam int PTR_HI_W      = PTR_W - 8;
    localparam int FRAME_W       = 4;

    localparam logic [4:0] BITS_BYTE  = 5'h08;
    localparam logic [4:0] BITS_WORD  = 5'h10;
    localparam logic [4:0] BITS_SAT   = 5'h1f;
    localparam logic [7:0] PANEL_MIN_CODE = 8'h01;
    localparam logic [7:0] PANEL_MIN_ON   = 8'h02;
    localparam logic [7:0] BLANK_LEAD     = 8'h02;
    localparam logic [7:0] ON_MAX         = 8'hfc;
    localparam logic [7:0] STEP_LAST      = 8'hff;
    localparam logic [FRAME_W-1:0] FRAME_LAST = 4'hb;
    localparam logic [PTR_W-1:0]   PTR_ONE    = 14'h0001;
    localparam logic [1:0] LVL_FULL = 2'b11;
    localparam logic [1:0] LVL_HIGH = 2'b10;
    localparam logic [1:0] LVL_LOW  = 2'b01;

    typedef enum logic [1:0] {SEQ_MANUAL, SEQ_SLOW, SEQ_FAST} seq_mode_e;

    // on-time in steps: n/256 of the panel value, trimmed to keep the blanking
    function automatic logic [7:0] digit_duty(input logic [7:0] panel, input logic [7:0] n);
        logic [7:0]  on;
        logic [15:0] prod;
        on = (panel == PANEL_MIN_CODE) ? PANEL_MIN_ON : panel;
        prod = 16'(on) * 16'(n);
        digit_duty = (prod[15:8] > ON_MAX) ? ON_MAX : prod[15:8];
    endfunction : digit_duty

    // whether a two-bit level is lit in a frame of the twelve-frame cycle
    function automatic logic level_lit(input logic [1:0] lvl, input logic geo,
                                       input logic [FRAME_W-1:0] fr);
        logic [1:0] m3;
        m3 = 2'(fr % 4'h3);
        case (lvl)
            LVL_FULL: level_lit = 1'b1;
            LVL_HIGH: level_lit = geo ? ~fr[0] : (m3 != 2'b01);
            LVL_LOW:  level_lit = geo ? (fr[1:0] == 2'b01) : (m3 == 2'b01);
            default:  level_lit = 1'b0;
        endcase
    endfunction : level_lit
endpackage : led_plane_pkg

/* rtl/serial_frame_port.sv */
// four-wire serial slave: collects 8 and 16 bit transfers, answers reads
`timescale 1ns/1ps
module serial_frame_port
    import led_plane_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic       i_cs_b,
    input  wire logic       i_sclk,
    input  wire logic       i_sdi,
    input  wire logic [7:0] i_rd_data,
    output logic      [6:0] o_rd_addr,
    output logic            o_wr_stb,
    output logic      [6:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    output logic            o_byte_stb,
    output logic            o_sdo
);
    import led_plane_pkg::*;

    logic [15:0] shift_reg;
    logic [7:0]  out_reg;
    logic [4:0]  cnt_reg;
    logic        sclk_reg;
    logic        cs_reg;
    logic        rise;
    logic        fall;
    logic        cs_end;

    assign rise      = i_sclk & ~sclk_reg;
    assign fall      = ~i_sclk & sclk_reg;
    assign cs_end    = i_cs_b & ~cs_reg;
    assign o_rd_addr = shift_reg[6:0];
    assign o_wr_addr = shift_reg[14:8];
    assign o_wr_data = shift_reg[7:0];

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sclk_reg <= 1'b0;
            cs_reg   <= 1'b1;
        end else if (i_ce) begin
            sclk_reg <= i_sclk;
            cs_reg   <= i_cs_b;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            shift_reg <= 16'h0000;
            cnt_reg   <= 5'h00;
        end else if (i_ce) begin
            if (i_cs_b) begin
                cnt_reg <= 5'h00;
            end else if (rise) begin
                shift_reg <= {shift_reg[14:0], i_sdi};
                if (cnt_reg != BITS_SAT) begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            end
        end
    end

    // commit only when chip select closes a whole transfer
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_wr_stb   <= 1'b0;
            o_byte_stb <= 1'b0;
        end else if (i_ce) begin
            o_wr_stb   <= cs_end && cnt_reg == BITS_WORD && !shift_reg[15];
            o_byte_stb <= cs_end && cnt_reg == BITS_BYTE;
        end
    end

    // header bit 7 set asks for read data in the second byte
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            out_reg <= 8'h00;
            o_sdo   <= 1'b0;
        end else if (i_ce) begin
            if (!i_cs_b && fall && cnt_reg == BITS_BYTE && shift_reg[7]) begin
                out_reg <= {i_rd_data[6:0], 1'b0};
                o_sdo   <= i_rd_data[7];
            end else if (!i_cs_b && fall && cnt_reg > BITS_BYTE) begin
                out_reg <= {out_reg[6:0], 1'b0};
                o_sdo   <= out_reg[7];
            end else if (i_cs_b) begin
                o_sdo <= 1'b0;
            end
        end
    end
endmodule : serial_frame_port

/* rtl/led_intensity_plane_control.sv */
// panel brightness pwm, digit scaling, pixel graduation and plane sequencing
//
// Behaviour
// - panel brightness register at 0x02 sets pwm
// - panel code 0x01 gives 2/256, 0xFF 255/256
// - separate intensity register for each digit
// - digit on-time is n/256 of panel value
// - effective digit duty never above 252/256
// - at least 4/256 of period blanked
// - depth bit: four one-bit or two two-bit planes
// - reduced variant: depth bit reads zero, ignores writes
// - two-bit levels: arithmetic or geometric graduation
// - graduation chosen separately per digit
// - driver select register at 0x08, any value
// - 14-bit memory pointer at 0x09 and 0x0A
// - 0x0B: fast bit, auto bit, six-bit setting
// - manual: low bits pick plane per depth
// - auto slow: one plane every n seconds
// - auto fast: n planes every second
// - digit registers at 0x03 and 0x04
// - two-bit levels made by frame modulation
// - driver select names driver answering reads; the block answers every read, the value only drives o_driver_select
// - pointer increments per byte, wraps to zero
`timescale 1ns/1ps
module led_intensity_plane_control
    import led_plane_pkg::*;
#(
    parameter logic [31:0] SEC_CYC          = led_plane_pkg::SEC_CYC_DEF,
    parameter bit          REDUCED_FEATURES = 1'b0
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_b,
    input  wire logic                           i_ce,
    input  wire logic                           i_cs_b,
    input  wire logic                           i_sclk,
    input  wire logic                           i_sdi,
    output logic                                o_sdo,
    output logic                          [1:0] o_digit_on,
    output logic                          [3:0] o_lit_d0,
    output logic                          [3:0] o_lit_d1,
    output logic                          [1:0] o_plane,
    output logic                                o_plane_depth,
    output logic                          [7:0] o_driver_select,
    output logic                                o_plane_step,
    output logic                                o_mem_wr,
    output logic [led_plane_pkg::PTR_W-1:0]     o_mem_addr,
    output logic                          [7:0] o_mem_data
);
    import led_plane_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    logic [6:0]       rd_addr;
    logic             wr_stb;
    logic [6:0]       wr_addr;
    logic [7:0]       wr_data;
    logic             byte_stb;
    logic [7:0]       rd_data;
    logic [7:0]       panel_reg;
    logic [7:0]       dig0_reg;
    logic [7:0]       dig1_reg;
    logic [7:0]       driver_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic [7:0]       seq_reg;
    logic             depth_reg;
    logic [1:0]       scale_reg;
    logic [1:0]       plane_reg;
    logic [31:0]      acc_reg;
    logic [31:0]      acc_next;
    logic [31:0]      acc_inc;
    logic [31:0]      acc_thr;
    logic [7:0]       cyc_reg;
    logic [7:0]       step_reg;
    logic             digit_reg;
    logic [FRAME_W-1:0] frame_reg;
    logic [7:0]       duty0;
    logic [7:0]       duty1;
    logic [SEQ_N_W-1:0] seq_n;
    logic             seq_wr;
    logic             cfg_wr;
    seq_mode_e        mode;

    serial_frame_port serial_frame_port_i (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_ce       (i_ce),
        .i_cs_b     (i_cs_b),
        .i_sclk     (i_sclk),
        .i_sdi      (i_sdi),
        .i_rd_data  (rd_data),
        .o_rd_addr  (rd_addr),
        .o_wr_stb   (wr_stb),
        .o_wr_addr  (wr_addr),
        .o_wr_data  (wr_data),
        .o_byte_stb (byte_stb),
        .o_sdo      (o_sdo)
    );

    assign seq_wr = i_ce && wr_stb && wr_addr == ADDR_SEQ;
    assign cfg_wr = i_ce && wr_stb && wr_addr == ADDR_CONFIG;
    assign seq_n  = seq_reg[SEQ_N_W-1:0];

    // read-back mux; the plane bits of the config register are read only
    always_comb begin
        case (rd_addr)
            ADDR_PANEL:  rd_data = panel_reg;
            ADDR_DIGIT0: rd_data = dig0_reg;
            ADDR_DIGIT1: rd_data = dig1_reg;
            ADDR_DRIVER: rd_data = driver_reg;
            ADDR_PTR_LO: rd_data = ptr_reg[7:0];
            ADDR_PTR_HI: rd_data = {2'b00, ptr_reg[PTR_W-1:8]};
            ADDR_SEQ:    rd_data = seq_reg;
            ADDR_CONFIG: rd_data = {depth_reg, 3'b000, plane_reg, 2'b00};
            ADDR_SCALE:  rd_data = {6'b00_0000, scale_reg};
            default:     rd_data = 8'h00;
        endcase
    end

    // brightness and scaling registers change only at a transfer's close
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            panel_reg  <= 8'h00;
            dig0_reg   <= 8'h00;
            dig1_reg   <= 8'h00;
            driver_reg <= 8'h00;
            scale_reg  <= 2'b00;
        end else if (i_ce && wr_stb) begin
            case (wr_addr)
                ADDR_PANEL:  panel_reg  <= wr_data;
                ADDR_DIGIT0: dig0_reg   <= wr_data;
                ADDR_DIGIT1: dig1_reg   <= wr_data;
                ADDR_DRIVER: driver_reg <= wr_data;
                ADDR_SCALE:  scale_reg  <= wr_data[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            depth_reg <= 1'b0;
        end else if (cfg_wr) begin
            depth_reg <= REDUCED_FEATURES ? 1'b0 : wr_data[CFG_DEPTH_BIT];
        end
    end

    // display memory pointer: register writes, then a step per data byte
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ptr_reg    <= '0;
            o_mem_wr   <= 1'b0;
            o_mem_addr <= '0;
            o_mem_data <= 8'h00;
        end else if (i_ce) begin
            o_mem_wr <= byte_stb;
            if (byte_stb) begin
                o_mem_addr <= ptr_reg;
                o_mem_data <= wr_data;
                ptr_reg    <= ptr_reg + PTR_ONE;
            end else if (wr_stb && wr_addr == ADDR_PTR_LO) begin
                ptr_reg[7:0] <= wr_data;
            end else if (wr_stb && wr_addr == ADDR_PTR_HI) begin
                ptr_reg[PTR_W-1:8] <= wr_data[PTR_HI_W-1:0];
            end
        end
    end

    // plane sequencer mode from the fast and auto bits
    always_comb begin
        if (!seq_reg[SEQ_AUTO_BIT]) begin
            mode = SEQ_MANUAL;
        end else if (seq_reg[SEQ_FAST_BIT]) begin
            mode = SEQ_FAST;
        end else begin
            mode = SEQ_SLOW;
        end
    end

    // fast adds n per cycle against one second; slow adds one against n seconds
    always_comb begin
        case (mode)
            SEQ_FAST: begin
                acc_inc = 32'(seq_n);
                acc_thr = SEC_CYC;
            end
            SEQ_SLOW: begin
                acc_inc = 32'h0000_0001;
                acc_thr = 32'(32'(seq_n) * SEC_CYC);
            end
            default: begin
                acc_inc = 32'h0000_0000;
                acc_thr = SEC_CYC;
            end
        endcase
        acc_next = acc_reg + acc_inc;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            seq_reg <= 8'h00;
        end else if (seq_wr) begin
            seq_reg <= wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            plane_reg    <= 2'b00;
            acc_reg      <= 32'h0000_0000;
            o_plane_step <= 1'b0;
        end else if (i_ce) begin
            o_plane_step <= 1'b0;
            if (seq_wr) begin
                acc_reg <= 32'h0000_0000;
                if (wr_data[SEQ_AUTO_BIT]) begin
                    plane_reg <= 2'b00;
                end else if (depth_reg) begin
                    plane_reg <= {1'b0, wr_data[0]};
                end else begin
                    plane_reg <= wr_data[1:0];
                end
            end else if (cfg_wr && !REDUCED_FEATURES && wr_data[CFG_DEPTH_BIT]) begin
                plane_reg <= {1'b0, plane_reg[0]};
            end else if (mode != SEQ_MANUAL && seq_n != '0) begin
                if (acc_next >= acc_thr) begin
                    acc_reg      <= acc_next - acc_thr;
                    o_plane_step <= 1'b1;
                    plane_reg    <= depth_reg ? {1'b0, ~plane_reg[0]} : plane_reg + 2'b01;
                end else begin
                    acc_reg <= acc_next;
                end
            end
        end
    end

    // scan timing: 256 steps per digit period, two digits per frame
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cyc_reg   <= 8'h00;
            step_reg  <= 8'h00;
            digit_reg <= 1'b0;
            frame_reg <= '0;
        end else if (i_ce) begin
            if (cyc_reg == 8'(STEP_CYC - 1)) begin
                cyc_reg  <= 8'h00;
                step_reg <= step_reg + 8'h01;
                if (step_reg == STEP_LAST) begin
                    digit_reg <= ~digit_reg;
                    if (digit_reg) begin
                        frame_reg <= (frame_reg == FRAME_LAST) ? '0 : frame_reg + 4'h1;
                    end
                end
            end else begin
                cyc_reg <= cyc_reg + 8'h01;
            end
        end
    end

    assign duty0 = digit_duty(panel_reg, dig0_reg);
    assign duty1 = digit_duty(panel_reg, dig1_reg);

    // lit window starts after the lead blank so both ends stay dark
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_digit_on <= 2'b00;
        end else if (i_ce) begin
            o_digit_on[0] <= !digit_reg && step_reg >= BLANK_LEAD
                             && step_reg < BLANK_LEAD + duty0;
            o_digit_on[1] <= digit_reg && step_reg >= BLANK_LEAD
                             && step_reg < BLANK_LEAD + duty1;
        end
    end

    // per-level lit flags for this frame; one-bit mode is plain on or off
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_lit_d0 <= 4'h0;
            o_lit_d1 <= 4'h0;
        end else if (i_ce) begin
            for (int l = 0; l < 4; l++) begin
                if (depth_reg) begin
                    o_lit_d0[l] <= level_lit(2'(l), scale_reg[0], frame_reg);
                    o_lit_d1[l] <= level_lit(2'(l), scale_reg[1], frame_reg);
                end else begin
                    o_lit_d0[l] <= l[0];
                    o_lit_d1[l] <= l[0];
                end
            end
        end
    end

    assign o_plane         = plane_reg;
    assign o_plane_depth   = depth_reg;
    assign o_driver_select = driver_reg;

    // per-frame lit patterns of the two-bit levels, bit k for frame k
    localparam logic [11:0] ARITH_HIGH = 12'hb6d;
    localparam logic [11:0] ARITH_LOW  = 12'h492;
    localparam logic [11:0] GEO_HIGH   = 12'h555;
    localparam logic [11:0] GEO_LOW    = 12'h222;

    panel_write_a: assert property (i_ce && wr_stb && wr_addr == ADDR_PANEL
        |=> panel_reg == $past(wr_data)) else $error("panel brightness not stored");
    min_code_a: assert property (panel_reg == PANEL_MIN_CODE && dig0_reg == STEP_LAST
        |-> duty0 == 8'h01) else $error("minimum panel code wrong duty");
    digit_start_a: assert property (i_ce && !digit_reg && step_reg == BLANK_LEAD && duty0 != 8'h00
        |=> o_digit_on[0]) else $error("digit 0 not lit at window start");
    tail_blank_a: assert property (i_ce && step_reg >= BLANK_LEAD + ON_MAX
        |=> o_digit_on == 2'b00) else $error("digit lit in tail blank");
    lead_blank_a: assert property (i_ce && step_reg < BLANK_LEAD
        |=> o_digit_on == 2'b00) else $error("digit lit in lead blank");
    depth_plane_a: assert property (depth_reg |-> !plane_reg[1])
        else $error("plane beyond two-plane range");
    reduced_depth_a: assert property (REDUCED_FEATURES |-> !depth_reg)
        else $error("depth bit set on reduced variant");
    arith_grad_a: assert property (i_ce && depth_reg && !scale_reg[0]
        |=> o_lit_d0 == {1'b1, ARITH_HIGH[$past(frame_reg)], ARITH_LOW[$past(frame_reg)], 1'b0})
        else $error("arithmetic level pattern wrong");
    geo_grad_a: assert property (i_ce && depth_reg && scale_reg[1]
        |=> o_lit_d1 == {1'b1, GEO_HIGH[$past(frame_reg)], GEO_LOW[$past(frame_reg)], 1'b0})
        else $error("geometric level pattern wrong");
    scale_write_a: assert property (i_ce && wr_stb && wr_addr == ADDR_SCALE
        |=> scale_reg == $past(wr_data[1:0])) else $error("scale bits not stored");
    driver_write_a: assert property (i_ce && wr_stb && wr_addr == ADDR_DRIVER
        |=> driver_reg == $past(wr_data)) else $error("driver select not stored");
    ptr_high_a: assert property (i_ce && wr_stb && wr_addr == ADDR_PTR_HI
        |=> ptr_reg[PTR_W-1:8] == $past(wr_data[PTR_HI_W-1:0])) else $error("pointer high bits wrong");
    manual_plane_a: assert property (seq_wr && !wr_data[SEQ_AUTO_BIT] && !depth_reg
        |=> plane_reg == $past(wr_data[1:0]) ##1 plane_reg == $past(wr_data[1:0], 2))
        else $error("manual plane not held");
    auto_init_a: assert property (seq_wr && wr_data[SEQ_AUTO_BIT]
        |=> plane_reg == 2'b00 && acc_reg == 32'h0000_0000) else $error("auto start not at plane 0");
    digit1_write_a: assert property (i_ce && wr_stb && wr_addr == ADDR_DIGIT1
        |=> dig1_reg == $past(wr_data)) else $error("digit 1 intensity not stored");
    ptr_step_a: assert property (i_ce && byte_stb
        |=> o_mem_wr && ptr_reg == $past(ptr_reg) + PTR_ONE) else $error("pointer did not step");
    mem_data_a: assert property (i_ce && byte_stb
        |=> o_mem_data == $past(wr_data) && o_mem_addr == $past(ptr_reg)) else $error("memory write wrong");
    zero_hold_a: assert property (i_ce && !seq_wr && !cfg_wr && seq_n == '0
        |=> $stable(plane_reg) && !o_plane_step) else $error("plane moved with zero setting");
    no_partial_a: assert property (!wr_stb
        |=> $stable(panel_reg) && $stable(dig0_reg) && $stable(seq_reg)) else $error("register changed mid transfer");
endmodule : led_intensity_plane_control

/* verification/serial_host_model.sv */
// host-side model of the four-wire serial master
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output logic      o_cs_b,
    output logic      o_sclk,
    output logic      o_sdi
);
    localparam int HALF = 3;

    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    // shifts count bits of word msb first; read data is taken in the last eight low phases
    task automatic xfer(input int count, input logic [15:0] word, output logic [7:0] rd);
        rd = 8'h00;
        step(1);
        o_cs_b = 1'b0;
        for (int i = 0; i < count; i++) begin
            o_sdi  = word[count-1-i];
            o_sclk = 1'b0;
            step(HALF);
            if (i >= 8) rd[15-i] = i_sdo;
            o_sclk = 1'b1;
            step(HALF);
        end
        o_sclk = 1'b0;
        step(HALF);
        o_cs_b = 1'b1;
        // a released data line does not keep its last bit
        o_sdi  = ~o_sdi;
        step(2);
    endtask : xfer
endmodule : serial_host_model

/* verification/led_intensity_plane_control_tb.sv */
// self-checking bench for the led intensity and plane block
`timescale 1ns/1ps
module led_intensity_plane_control_tb;
    import led_plane_pkg::*;
    localparam logic [31:0] SEC_T = 32'h0000_00c8;
    localparam int          FRAME = 2 * STEPS * STEP_CYC;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cs_b, sclk, sdi, sdo_full, sdo_red, sel_red, depth, depth_red, step_p, mem_wr;
    logic [1:0]  digit_on, plane;
    logic [3:0]  lit_d0, lit_d1;
    logic [7:0]  drv, mem_data;
    logic [13:0] mem_addr;
    logic [21:0] mem_q[$];
    logic [6:0]  addr_t[7] = '{7'h02, 7'h03, 7'h04, 7'h08, 7'h09, 7'h0a, 7'h7f};
    logic [7:0]  data_t[7] = '{8'ha5, 8'h5a, 8'hc3, 8'hff, 8'hff, 8'hff, 8'h12};
    logic [7:0]  back_t[7] = '{8'ha5, 8'h5a, 8'hc3, 8'hff, 8'hff, 8'h3f, 8'h00};
    logic [6:0]  zero_t[9] = '{7'h02, 7'h03, 7'h04, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0d, 7'h0e};
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          gap;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (mem_wr === 1'b1) mem_q.push_back({mem_addr, mem_data});


    serial_host_model serial_host_model_i (.i_clk(clk), .i_sdo(sel_red ? sdo_red : sdo_full),
        .o_cs_b(cs_b), .o_sclk(sclk), .o_sdi(sdi));

    led_intensity_plane_control #(.SEC_CYC(SEC_T), .REDUCED_FEATURES(1'b0)) led_intensity_plane_control_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_cs_b(cs_b), .i_sclk(sclk), .i_sdi(sdi),
        .o_sdo(sdo_full), .o_digit_on(digit_on), .o_lit_d0(lit_d0), .o_lit_d1(lit_d1), .o_plane(plane),
        .o_plane_depth(depth), .o_driver_select(drv), .o_plane_step(step_p), .o_mem_wr(mem_wr),
        .o_mem_addr(mem_addr), .o_mem_data(mem_data));

    led_intensity_plane_control #(.SEC_CYC(SEC_T), .REDUCED_FEATURES(1'b1)) led_intensity_plane_control_i_red (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_cs_b(cs_b), .i_sclk(sclk), .i_sdi(sdi),
        .o_sdo(sdo_red), .o_digit_on(), .o_lit_d0(), .o_lit_d1(), .o_plane(), .o_plane_depth(depth_red),
        .o_driver_select(), .o_plane_step(), .o_mem_wr(), .o_mem_addr(), .o_mem_data());

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        serial_host_model_i.xfer(16, {1'b0, a, d}, r);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        serial_host_model_i.xfer(16, {1'b1, a, 8'h00}, r);
        check(24'(r), 24'(exp));
    endtask : rd_chk

    // on-cycles of each digit over one whole frame, after a frame to settle
    task automatic duty(input logic [7:0] e0, input logic [7:0] e1);
        int c0, c1;
        c0 = 0;
        c1 = 0;
        step(FRAME);
        for (int k = 0; k < FRAME; k++) begin
            c0 += int'(digit_on[0] === 1'b1);
            c1 += int'(digit_on[1] === 1'b1);
            step(1);
        end
        check(24'(c0), 24'(e0) * 24'(STEP_CYC));
        check(24'(c1), 24'(e1) * 24'(STEP_CYC));
    endtask : duty

    // cycles from one plane advance pulse to the next
    task automatic pulse_gap(output int n);
        for (int p = 0; p < 2; p++) begin
            n = 1;
            while (step_p !== 1'b1 && n < 5000) begin
                step(1);
                n++;
            end
            if (n == 5000) begin
                n_mismatch++;
                final_report();
            end
            step(1);
        end
    endtask : pulse_gap

    initial begin
        logic [7:0] r;
        sel_red = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        step(1);
        foreach (zero_t[i]) rd_chk(zero_t[i], 8'h00);
        check(24'({lit_d1, lit_d0}), 24'h00_00aa);
        foreach (addr_t[i]) begin
            wr(addr_t[i], data_t[i]);
            rd_chk(addr_t[i], back_t[i]);
        end
        check(24'(drv), 24'h00_00ff);
        serial_host_model_i.xfer(8, 16'h005a, r);
        serial_host_model_i.xfer(8, 16'h00c3, r);
        step(4);
        check(24'(mem_q.size()), 24'h00_0002);
        check(24'(mem_q[0]), {2'b00, 14'h3fff, 8'h5a});
        check(24'(mem_q[1]), {2'b00, 14'h0000, 8'hc3});
        rd_chk(7'h09, 8'h01);
        wr(7'h02, 8'hff);
        wr(7'h03, 8'hff);
        wr(7'h04, 8'h40);
        duty(8'hfc, 8'h3f);
        wr(7'h02, 8'h01);
        wr(7'h03, 8'h80);
        wr(7'h04, 8'hff);
        duty(8'h01, 8'h01);
        wr(7'h0b, 8'h03);
        check(24'(plane), 24'h00_0003);
        rd_chk(7'h0d, 8'h0c);
        wr(7'h0d, 8'h80);
        wr(7'h0e, 8'h02);
        rd_chk(7'h0d, 8'h84);
        check(24'({depth, lit_d0[3], lit_d0[0]}), 24'h00_0006);
        check(24'({lit_d0[2] ^ lit_d0[1], lit_d1[2] & lit_d1[1], lit_d1[3], lit_d1[0]}), 24'h00_000a);
        rd_chk(7'h0e, 8'h02);
        sel_red = 1'b1;
        rd_chk(7'h0d, 8'h0c);
        sel_red = 1'b0;
        check(24'(depth_red), 24'h00_0000);
        wr(7'h0b, 8'h02);
        check(24'(plane), 24'h00_0000);
        wr(7'h0b, 8'h03);
        check(24'(plane), 24'h00_0001);
        wr(7'h0b, 8'hc4);
        check(24'(plane), 24'h00_0000);
        pulse_gap(gap);
        check(24'(gap), 24'(SEC_T / 32'h0000_0004));
        check(24'(plane), 24'h00_0000);
        wr(7'h0b, 8'h42);
        pulse_gap(gap);
        check(24'(gap), 24'(SEC_T * 32'h0000_0002));
        wr(7'h0b, 8'h40);
        gap = 0;
        for (int k = 0; k < 1000; k++) begin
            gap += int'(step_p === 1'b1);
            step(1);
        end
        check(24'(gap), 24'h00_0000);
        final_report();
    end
endmodule : led_intensity_plane_control_tb
